// ---- rtl/ppmc_defines.vh ----
// constants for the power-management capability register bank
// assumes config accesses arrive as single-cycle strobes on the core clock
`ifndef PPMC_DEFINES_VH
`define PPMC_DEFINES_VH

// ----------------------------------------
// register selects (offsets within the capability block)
// ----------------------------------------
`define PPMC_SEL_CAP 1'b0
`define PPMC_SEL_CSR 1'b1

// ----------------------------------------
// capability fields
// ----------------------------------------
`define PPMC_VERSION 3'h2
`define PPMC_WAKE_STATES 4'hf
`define PPMC_AUX_LO 6
`define PPMC_AUX_HI 8
`define PPMC_D3C_BIT 15
`define PPMC_AUX_RST 3'h0
`define PPMC_D3C_RST 1'b0

// ----------------------------------------
// control/status fields
// ----------------------------------------
`define PPMC_PS_LO 1
`define PPMC_PS_HI 0
`define PPMC_PS_D0 2'h0
`define PPMC_PS_RST 2'h0
`define PPMC_EN_BIT 8
`define PPMC_ST_BIT 15

// ----------------------------------------
// fixed read bits, lanes and sync stages
// ----------------------------------------
`define PPMC_BE_LO 0
`define PPMC_BE_HI 1
`define PPMC_LO_BYTE_MSB 7
`define PPMC_AUX_WIDTH 3
`define PPMC_DEEP_SLEEP 1'b1
`define PPMC_LIGHT_SLEEP 1'b1
`define PPMC_DSI 1'b0
`define PPMC_RSVD_BIT 1'b0
`define PPMC_CLK_FREE 1'b0
`define PPMC_DATA_ZERO 6'h00
`define PPMC_RSVD_ZERO 6'h00
`define PPMC_SYNC_MID 1
`define PPMC_SYNC_LAST 2
`define PPMC_SYNC_RST 3'h0
`define PPMC_RDATA_RST 16'h0000
`define PPMC_OUT_RST 1'b0

`endif

// ---- rtl/ppmc_pm_regs.v ----
// power-management capability and control/status registers of one host core,
// plus the legacy io space indicator bit.
// assumes config writes/reads are one-cycle strobes from the config decoder.
//
// Behaviour
// - legacy decode bit 0: io space indicator reads 0
// - legacy decode bit 1: io space indicator follows synchronised legacy strap pin
// - one legacy controller shared; its io address lives in first core only
// - capability version bits 2:0 read 010b
// - capability bit 3 reads 0, no pci clock needed for wake
// - capability bit 5 reads 0, no special init needed
// - aux current bits 8:6 reset 000b, writable when unlocked
// - capability bits 9 and 10 read 1, light and deep sleep
// - capability bits 14:11 read 1111b
// - capability bit 15 is cold-wake support, reset 0
// - aux current and cold-wake bit writable only while unlock bit is 1
// - serial rom loader may preload writable capability fields before config access
// - power state bits 1:0 read/write, reset 00b
// - control bit 8 enables wake output
// - wake enable resets 0 without cold-wake support
// - with cold-wake support enable and status survive reset
// - data select and data scale read zero
// - status bit 15 sets on resume flag rise, regardless of enable
// - writing 1 to status bit clears it
// - wake status resets 0 without cold-wake support
// - power state not D0 means global suspend, clock stopped

`include "ppmc_defines.vh"

module ppmc_pm_regs (
    // clock and reset
    input wire ref_clk_i,
    input wire reset_n_i,
    // configuration access
    input wire cfg_wr_i,
    input wire cfg_rd_i,
    input wire cfg_sel_i,
    input wire [1:0] cfg_be_i,
    input wire [15:0] cfg_wdata_i,
    output reg [15:0] cfg_rdata_o,
    // serial rom preload
    input wire rom_load_i,
    input wire [2:0] rom_aux_current_i,
    input wire rom_cold_wake_i,
    // chip-level inputs
    input wire ident_write_unlock_i,
    input wire legacy_decode_sel_i,
    input wire legacy_strap_i,
    input wire resume_seen_flag_i,
    // outputs
    output reg io_space_ind_o,
    output reg wake_o,
    output reg global_suspend_o
);

// ----------------------------------------
// state
// ----------------------------------------
reg [2:0] aux_current;
reg cold_wake;
reg [1:0] power_state;
reg wake_assert_enable;
reg wake_event_flag;
reg resume_d;
reg [2:0] strap_sync;
reg strap_level;
wire [15:0] cap_word;
wire [15:0] csr_word;
wire cap_wr_lo;
wire cap_wr_hi;
wire csr_wr_lo;
wire csr_wr_hi;
wire resume_rise;

// ----------------------------------------
// write strobes per register and byte lane
// ----------------------------------------
assign cap_wr_lo = cfg_wr_i & (cfg_sel_i == `PPMC_SEL_CAP) & cfg_be_i[`PPMC_BE_LO];
assign cap_wr_hi = cfg_wr_i & (cfg_sel_i == `PPMC_SEL_CAP) & cfg_be_i[`PPMC_BE_HI];
assign csr_wr_lo = cfg_wr_i & (cfg_sel_i == `PPMC_SEL_CSR) & cfg_be_i[`PPMC_BE_LO];
assign csr_wr_hi = cfg_wr_i & (cfg_sel_i == `PPMC_SEL_CSR) & cfg_be_i[`PPMC_BE_HI];

// ----------------------------------------
// read words
// ----------------------------------------
// fixed version
assign cap_word = {
    cold_wake,
    `PPMC_WAKE_STATES,
    `PPMC_DEEP_SLEEP,
    `PPMC_LIGHT_SLEEP,
    aux_current,
    `PPMC_DSI,
    `PPMC_RSVD_BIT,
    `PPMC_CLK_FREE,
    `PPMC_VERSION
};
assign csr_word = {
    wake_event_flag,
    `PPMC_DATA_ZERO,
    wake_assert_enable,
    `PPMC_RSVD_ZERO,
    power_state
};

// ----------------------------------------
// capability writable fields
// ----------------------------------------
wire cap_unlocked_wr;
wire [2:0] next_aux_current;
reg next_cold_wake;

assign cap_unlocked_wr = ident_write_unlock_i & ~rom_load_i;

// aux current, lane picked per bit
genvar aux_idx;
generate
    for (aux_idx = 0; aux_idx < `PPMC_AUX_WIDTH; aux_idx = aux_idx + 1) begin : g_aux_bit
        localparam integer BIT_POS = `PPMC_AUX_LO + aux_idx;
        wire lane_wr;
        assign lane_wr = (BIT_POS > `PPMC_LO_BYTE_MSB) ? cap_wr_hi : cap_wr_lo;
        assign next_aux_current[aux_idx] = (cap_unlocked_wr & lane_wr) ?
            cfg_wdata_i[BIT_POS] : aux_current[aux_idx];
    end
endgenerate

always @* begin
    next_cold_wake = cold_wake;
    if (cap_unlocked_wr & cap_wr_hi) begin
        next_cold_wake = cfg_wdata_i[`PPMC_D3C_BIT];
    end
end

always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        aux_current <= `PPMC_AUX_RST;
        cold_wake <= `PPMC_D3C_RST;
    end else if (rom_load_i) begin
        aux_current <= rom_aux_current_i;
        cold_wake <= rom_cold_wake_i;
    end else begin
        aux_current <= next_aux_current;
        cold_wake <= next_cold_wake;
    end
end

// ----------------------------------------
// power state
// ----------------------------------------
reg [1:0] next_power_state;

always @* begin
    next_power_state = power_state;
    if (csr_wr_lo) begin
        next_power_state = cfg_wdata_i[`PPMC_PS_LO:`PPMC_PS_HI];
    end
end

always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        power_state <= `PPMC_PS_RST;
    end else begin
        power_state <= next_power_state;
    end
end

// ----------------------------------------
// wake enable and status
// ----------------------------------------
reg next_wake_assert_enable;
reg next_wake_event_flag;
wire sticky_hold;

// no reset: the detector tracks the flag through reset, so no false edge follows
always @(posedge ref_clk_i) begin
    resume_d <= resume_seen_flag_i;
end
assign resume_rise = resume_seen_flag_i & ~resume_d;

always @* begin
    next_wake_assert_enable = wake_assert_enable;
    if (csr_wr_hi) begin
        next_wake_assert_enable = cfg_wdata_i[`PPMC_EN_BIT];
    end
end

// resume set wins over write-one clear
always @* begin
    next_wake_event_flag = wake_event_flag;
    if (resume_rise) begin
        next_wake_event_flag = 1'b1;
    end else if (csr_wr_hi & cfg_wdata_i[`PPMC_ST_BIT]) begin
        next_wake_event_flag = 1'b0;
    end
end

// cold-wake support is restored from rom, so the rom value decides stickiness
assign sticky_hold = rom_cold_wake_i;

// cleared during reset only without cold-wake support
always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
        if (!sticky_hold) begin
            wake_assert_enable <= 1'b0;
            wake_event_flag <= 1'b0;
        end
    end else begin
        wake_assert_enable <= next_wake_assert_enable;
        wake_event_flag <= next_wake_event_flag;
    end
end

// ----------------------------------------
// legacy strap sync
// ----------------------------------------
reg next_strap_level;

// level taken once second and third flops agree
always @* begin
    next_strap_level = strap_level;
    if (strap_sync[`PPMC_SYNC_LAST] == strap_sync[`PPMC_SYNC_MID]) begin
        next_strap_level = strap_sync[`PPMC_SYNC_LAST];
    end
end

always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        strap_sync <= `PPMC_SYNC_RST;
        strap_level <= `PPMC_OUT_RST;
    end else begin
        strap_sync <= {strap_sync[`PPMC_SYNC_MID:0], legacy_strap_i};
        strap_level <= next_strap_level;
    end
end

// ----------------------------------------
// read mux
// ----------------------------------------
reg [15:0] next_cfg_rdata;

always @* begin
    next_cfg_rdata = cfg_rdata_o;
    if (cfg_rd_i) begin
        case (cfg_sel_i)
            `PPMC_SEL_CAP: begin
                next_cfg_rdata = cap_word;
            end
            `PPMC_SEL_CSR: begin
                next_cfg_rdata = csr_word;
            end
            default: begin
                next_cfg_rdata = cap_word;
            end
        endcase
    end
end

// ----------------------------------------
// outputs, each from its own flop
// ----------------------------------------
reg next_io_space_ind;
reg next_wake;
reg next_global_suspend;

// indicator for the shared legacy controller
always @* begin
    next_io_space_ind = legacy_decode_sel_i & strap_level;
end

always @* begin
    next_wake = wake_assert_enable & wake_event_flag;
end

always @* begin
    next_global_suspend = (power_state != `PPMC_PS_D0);
end

always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        cfg_rdata_o <= `PPMC_RDATA_RST;
    end else begin
        cfg_rdata_o <= next_cfg_rdata;
    end
end

always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        io_space_ind_o <= `PPMC_OUT_RST;
    end else begin
        io_space_ind_o <= next_io_space_ind;
    end
end

always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        wake_o <= `PPMC_OUT_RST;
    end else begin
        wake_o <= next_wake;
    end
end

always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        global_suspend_o <= `PPMC_OUT_RST;
    end else begin
        global_suspend_o <= next_global_suspend;
    end
end

endmodule // ppmc_pm_regs

// ---- verification/ppmc_pm_regs_assertions.sv ----
// assertions on the pm register bank ports
// assumes a bind onto ppmc_pm_regs
module ppmc_pm_regs_assertions (
    input wire ref_clk_i, reset_n_i, cfg_wr_i, cfg_rd_i, cfg_sel_i,
    input wire [1:0] cfg_be_i,
    input wire [15:0] cfg_wdata_i, cfg_rdata_o,
    input wire legacy_decode_sel_i, legacy_strap_i, resume_seen_flag_i,
    input wire io_space_ind_o, wake_o, global_suspend_o
);
    wire cap_rd = cfg_rd_i & ~cfg_sel_i;
    wire csr_rd = cfg_rd_i & cfg_sel_i;
    wire hi_wr = cfg_wr_i & cfg_sel_i & cfg_be_i[1];
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_IO_OFF: assert property (!legacy_decode_sel_i |=> !io_space_ind_o)
        else $error("io bit set");
    AST_IO_ON: assert property ((legacy_decode_sel_i && $stable(legacy_strap_i)) [*6]
        |=> io_space_ind_o == $past(legacy_strap_i)) else $error("io bit wrong");
    AST_CAP: assert property (cap_rd |=>
        cfg_rdata_o[5:0] == 6'h02 && cfg_rdata_o[14:9] == 6'h3f) else $error("cap bits");
    AST_CSR: assert property (csr_rd |=>
        cfg_rdata_o[14:9] == 6'h00 && cfg_rdata_o[7:2] == 6'h00) else $error("csr bits");
    AST_SUSP: assert property (cfg_wr_i && cfg_sel_i && cfg_be_i[0] |=> ##1
        global_suspend_o == (($past(cfg_wdata_i, 2) & 16'h0003) != 16'h0000))
        else $error("suspend wrong");
    AST_EN_OFF: assert property (hi_wr && !cfg_wdata_i[8] |=> ##1 !wake_o)
        else $error("wake while off");
    AST_RESUME: assert property ($rose(resume_seen_flag_i) ##1 csr_rd |=> cfg_rdata_o[15])
        else $error("status not set");
    AST_CLEAR: assert property (hi_wr && cfg_wdata_i[15] && !resume_seen_flag_i
        ##1 (!resume_seen_flag_i) [*3] ##0 csr_rd |=> !cfg_rdata_o[15]) else $error("not clr");
endmodule // ppmc_pm_regs_assertions

bind ppmc_pm_regs ppmc_pm_regs_assertions chk (.*);

// ---- verification/ppmc_host_model.sv ----
// config-cycle host model for the pm register bank
// assumes one clock; cycles launched at rising edges
module ppmc_host_model (
    input wire ref_clk_i,
    input wire [15:0] rdata_i,
    output logic wr_o, rd_o, sel_o,
    output logic [1:0] be_o,
    output logic [15:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        sel_o = 1'b0;
        be_o = 2'h0;
        wdata_o = 16'h0000;
    end
    task automatic wr(input logic s, input logic [1:0] b, input logic [15:0] d);
        @(posedge ref_clk_i);
        wr_o <= 1'b1;
        sel_o <= s;
        be_o <= b;
        wdata_o <= d;
        @(posedge ref_clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic s, output logic [15:0] q);
        @(posedge ref_clk_i);
        rd_o <= 1'b1;
        sel_o <= s;
        @(posedge ref_clk_i);
        rd_o <= 1'b0;
        #1 q = rdata_i;
    endtask
endmodule // ppmc_host_model

// ---- verification/ppmc_testbench.sv ----
// bench for the pm register bank
// assumes the host model runs every config cycle
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic sel; logic [1:0] be; logic [15:0] d, e; logic s;} ppmc_row_t;
    logic ref_clk_i, reset_n_i, cfg_wr_i, cfg_rd_i, cfg_sel_i, rom_load_i, rom_cold_wake_i;
    logic ident_write_unlock_i, legacy_decode_sel_i, legacy_strap_i, resume_seen_flag_i;
    logic io_space_ind_o, wake_o, global_suspend_o;
    logic [1:0] cfg_be_i;
    logic [2:0] rom_aux_current_i;
    logic [15:0] cfg_wdata_i, cfg_rdata_o, q;
    int fail_count = 0;
    int comparisons = 0;
    ppmc_row_t rows [5] = '{'{1'b0, 2'h3, 16'hffff, 16'h7e02, 1'b0},
        '{1'b1, 2'h1, 16'h0002, 16'h0002, 1'b1}, '{1'b1, 2'h1, 16'h0003, 16'h0003, 1'b1},
        '{1'b1, 2'h3, 16'h0100, 16'h0100, 1'b0}, '{1'b1, 2'h2, 16'h7e00, 16'h0000, 1'b0}};
    ppmc_pm_regs dut (.*);
    ppmc_host_model host (.ref_clk_i(ref_clk_i), .rdata_i(cfg_rdata_o), .wr_o(cfg_wr_i),
        .rd_o(cfg_rd_i), .sel_o(cfg_sel_i), .be_o(cfg_be_i), .wdata_o(cfg_wdata_i));
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic csr_step(input logic [15:0] d, input logic r, e15, input logic [15:0] e);
        host.wr(1'b1, 2'h2, d);
        @(posedge ref_clk_i);
        resume_seen_flag_i <= r;
        host.rd(1'b1, q);
        check("csr", q, e);
        check("wake", wake_o, e15);
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        reset_n_i = 1'b0;
        {rom_load_i, rom_cold_wake_i, ident_write_unlock_i, resume_seen_flag_i} = 4'h0;
        {legacy_decode_sel_i, legacy_strap_i, rom_aux_current_i} = 5'h05;
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        host.rd(1'b1, q);
        check("csr rst", q, 16'h0000);
        foreach (rows[i]) begin
            host.wr(rows[i].sel, rows[i].be, rows[i].d);
            host.rd(rows[i].sel, q);
            check("row", q, rows[i].e);
            check("susp", global_suspend_o, rows[i].s);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk_i);
            {legacy_decode_sel_i, legacy_strap_i} <= k[1:0];
            repeat (8) @(posedge ref_clk_i);
            check("io", io_space_ind_o, k[1] & k[0]);
        end
        ident_write_unlock_i <= 1'b1;
        host.wr(1'b0, 2'h3, 16'hffff);
        host.rd(1'b0, q);
        check("cap open", q, 16'hffc2);
        rom_load_i <= 1'b1;
        @(posedge ref_clk_i);
        rom_load_i <= 1'b0;
        host.rd(1'b0, q);
        check("cap rom", q, 16'h7f42);
        csr_step(16'h0000, 1'b1, 1'b0, 16'h8000);
        csr_step(16'h0100, 1'b0, 1'b1, 16'h8100);
        csr_step(16'h8000, 1'b0, 1'b0, 16'h0000);
        csr_step(16'h0100, 1'b1, 1'b1, 16'h8100);
        rom_cold_wake_i <= 1'b1;
        host.wr(1'b0, 2'h2, 16'h8000);
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        host.rd(1'b1, q);
        check("sticky", q, 16'h8100);
        rom_cold_wake_i <= 1'b0;
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        host.rd(1'b1, q);
        check("not sticky", q, 16'h0000);
        complete_run();
    end
endmodule // testbench
